// >>> hw/epi_change_group.sv
// asynchronous pin-change detect for one group, wake level plus clocked flag set
`timescale 1ns/1ps
`default_nettype none
module epi_change_group
   import epi_pkg::*;
#(
   parameter int W = 8
)(
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // pins and mask
   input  wire logic [W-1:0] pins,
   input  wire logic [W-1:0] mask,
   input  wire logic         group_enable,
   // detection
   output var  logic         wake,
   output var  logic         change
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] ref_level;
   } epi_grp_t;
   epi_grp_t st;
   epi_grp_t next_st;
   logic [W-1:0] active;

   // async compare against the last accepted level gives a wake level without a clock
   genvar i;
   for (i = 0; i < W; i++) begin : g_pin
      assign active[i] = mask[i] & group_enable & (pins[i] ^ st.ref_level[i]);
   end

   always_comb begin
      next_st           = st;
      next_st.meta      = pins;
      next_st.sync      = st.meta;
      next_st.ref_level = st.sync;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign wake   = |active;
   assign change = |(mask & (st.sync ^ st.ref_level)) & group_enable;
endmodule : epi_change_group
`default_nettype wire

// >>> hw/epi_pin_sync.sv
// two-stage synchroniser with edge flags for one dedicated pin
`timescale 1ns/1ps
`default_nettype none
module epi_pin_sync
   import epi_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // pin
   input  wire logic pin,
   // sampled value and edge pulses
   output var  logic level,
   output var  logic rise,
   output var  logic fall
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } epi_sync_t;
   epi_sync_t st;
   epi_sync_t next_st;

   always_comb begin
      next_st      = st;
      next_st.meta = pin;
      next_st.sync = st.meta;
      next_st.last = st.sync;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.sync;
   assign rise  = st.sync & ~st.last;
   assign fall  = ~st.sync & st.last;
endmodule : epi_pin_sync
`default_nettype wire

// >>> hw/epi_pkg.sv
// package of offsets, fields and reset values for the external pin interrupt unit
package epi_pkg;
   // data-space byte offsets
   localparam logic [7:0] EPI_OFS_PC_FLAGS    = 8'h3b;
   localparam logic [7:0] EPI_OFS_EXT_FLAGS   = 8'h3c;
   localparam logic [7:0] EPI_OFS_EXT_ENABLE  = 8'h3d;
   localparam logic [7:0] EPI_OFS_PC_CONTROL  = 8'h68;
   localparam logic [7:0] EPI_OFS_SENSE       = 8'h69;
   localparam logic [7:0] EPI_OFS_PC_MASK0    = 8'h6b;
   localparam logic [7:0] EPI_OFS_PC_MASK1    = 8'h6c;
   localparam logic [7:0] EPI_OFS_PC_MASK2    = 8'h6d;
   localparam logic [7:0] EPI_IO_SPACE_BASE   = 8'h20;
   localparam logic [7:0] EPI_EXT_SPACE_BASE  = 8'h60;
   localparam logic [7:0] EPI_REG_RESET       = 8'h00;
   // sense field positions
   localparam int EPI_SENSE_PIN0_LSB = 0;
   localparam int EPI_SENSE_PIN1_LSB = 2;
   // group widths
   localparam int EPI_GROUP0_W = 8;
   localparam int EPI_GROUP1_W = 7;
   localparam int EPI_GROUP2_W = 8;
   localparam int EPI_SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      EPI_SENSE_LOW     = 2'h0,
      EPI_SENSE_CHANGE  = 2'h1,
      EPI_SENSE_FALLING = 2'h2,
      EPI_SENSE_RISING  = 2'h3
   } epi_sense_t;
endpackage : epi_pkg

// >>> hw/epi_unit.sv
// external pin interrupt unit: dedicated pins, pin-change groups, registers
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - pin activity raises requests even when the pins are driven as outputs.
// - group 2 pins 23:16, group 1 pins 14:8, group 0 pins 7:0 raise on toggle.
// - per-group mask registers pick which inputs feed each pin-change request.
// - pin changes detected without clock so they can wake from deep sleep; here wake_req is still registered on sys_clk.
// - level mode keeps requesting while the enabled pin stays low.
// - edges on dedicated pins detected on the clock, stopped in deep sleep.
// - low level on dedicated pins detected without clock for wake-up; here wake_req is still registered on sys_clk.
// - pin one sense bits 3:2: low, any change, falling, rising.
// - pin zero sense bits 1:0 with the same encoding.
// - pins sampled before edge detection; pulses over one clock always caught.
// - dedicated request active only with global flag and pin enable set.
// - enable bit 1 for pin one, bit 0 for pin zero, each its own vector.
// - flag bit 1 or 0 set when an edge or change triggers a request.
// - dedicated flag cleared on routine entry or by writing one.
// - flag reads cleared while its pin is in level mode.
// - low registers also reached at offset minus 0x20; 0x60 up data space only.
// - each group enabled by its control bit plus the global flag, own vector.
// - group flag set on change, cleared on entry or by writing one.
// - mask bit enables its pin only with group control bit set.
module epi_unit
   import epi_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_io_space,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output var  logic [7:0]  reg_rdata,
   // core interface
   input  wire logic        core_status_word_i,
   input  wire logic [4:0]  irq_ack,
   output var  logic [4:0]  irq_req,
   output var  logic        wake_req,
   // pins
   input  wire logic        ext_irq_pin_zero,
   input  wire logic        ext_irq_pin_one,
   input  wire logic [23:0] pin_change_input
);
   typedef struct packed {
      logic [7:0] ext_irq_flags;
      logic [7:0] ext_irq_enable_mask;
      logic [7:0] ext_irq_sense_control;
      logic [7:0] pin_change_flags;
      logic [7:0] pin_change_group_control;
      logic [7:0] pin_change_mask_group0;
      logic [7:0] pin_change_mask_group1;
      logic [7:0] pin_change_mask_group2;
      logic [7:0] rdata;
      logic [4:0] req;
      logic       wake;
   } epi_state_t;

   epi_state_t st;
   epi_state_t next_st;
   logic       rst_n;
   logic [1:0] lvl;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] trig;
   logic [1:0] level_mode;
   logic [2:0] grp_wake;
   logic [2:0] grp_change;
   logic [7:0] addr;
   logic       low_wake;
   logic [1:0] low_hit;
   logic [1:0] pin_raw;
   logic [1:0] ded_src;
   logic [1:0] ext_clr;
   logic [2:0] grp_clr;
   logic       hit_pc_flags;
   logic       hit_ext_flags;
   logic       hit_ext_enable;
   logic       hit_pc_control;
   logic       hit_sense;
   logic       hit_pc_mask0;
   logic       hit_pc_mask1;
   logic       hit_pc_mask2;
   logic [1:0] rst_sync;
   epi_sense_t sense [2];

   // reset release through two flops, kept apart from the state record
   // since it runs on the raw reset
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // dedicated pins sampled regardless of port direction
   epi_pin_sync u_sync0 (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin     (ext_irq_pin_zero),
      .level   (lvl[0]),
      .rise    (rise[0]),
      .fall    (fall[0])
   );
   epi_pin_sync u_sync1 (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin     (ext_irq_pin_one),
      .level   (lvl[1]),
      .rise    (rise[1]),
      .fall    (fall[1])
   );

   assign sense[0] = epi_sense_t'(st.ext_irq_sense_control[EPI_SENSE_PIN0_LSB +: 2]);
   assign sense[1] = epi_sense_t'(st.ext_irq_sense_control[EPI_SENSE_PIN1_LSB +: 2]);

   genvar p;
   for (p = 0; p < 2; p++) begin : g_ded
      assign level_mode[p] = (sense[p] == EPI_SENSE_LOW);
      assign ded_src[p]    = level_mode[p] ? ~lvl[p] : st.ext_irq_flags[p];
      always_comb begin
         case (sense[p])
            EPI_SENSE_CHANGE:  trig[p] = rise[p] | fall[p];
            EPI_SENSE_FALLING: trig[p] = fall[p];
            EPI_SENSE_RISING:  trig[p] = rise[p];
            default:           trig[p] = 1'b0;
         endcase
      end
   end

   // low level wake path, straight from the pins with no clock
   assign pin_raw = {ext_irq_pin_one, ext_irq_pin_zero};
   genvar c;
   for (c = 0; c < 2; c++) begin : g_low
      assign low_hit[c] = st.ext_irq_enable_mask[c] & level_mode[c] & ~pin_raw[c];
   end
   assign low_wake = |low_hit;

   epi_change_group #(.W(EPI_GROUP0_W)) u_grp0 (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .pins         (pin_change_input[7:0]),
      .mask         (st.pin_change_mask_group0[7:0]),
      .group_enable (st.pin_change_group_control[0]),
      .wake         (grp_wake[0]),
      .change       (grp_change[0])
   );
   epi_change_group #(.W(EPI_GROUP1_W)) u_grp1 (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .pins         (pin_change_input[14:8]),
      .mask         (st.pin_change_mask_group1[6:0]),
      .group_enable (st.pin_change_group_control[1]),
      .wake         (grp_wake[1]),
      .change       (grp_change[1])
   );
   epi_change_group #(.W(EPI_GROUP2_W)) u_grp2 (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .pins         (pin_change_input[23:16]),
      .mask         (st.pin_change_mask_group2[7:0]),
      .group_enable (st.pin_change_group_control[2]),
      .wake         (grp_wake[2]),
      .change       (grp_change[2])
   );

   // io-space accesses below 0x40 map to data space offset plus 0x20; higher ones hit nothing
   always_comb begin
      if (reg_io_space) begin
         addr = (reg_addr < 8'h40) ? reg_addr + EPI_IO_SPACE_BASE : 8'hff;
      end else begin
         addr = reg_addr;
      end
   end

   // register selects after address mapping
   assign hit_pc_flags   = (addr == EPI_OFS_PC_FLAGS);
   assign hit_ext_flags  = (addr == EPI_OFS_EXT_FLAGS);
   assign hit_ext_enable = (addr == EPI_OFS_EXT_ENABLE);
   assign hit_pc_control = (addr == EPI_OFS_PC_CONTROL);
   assign hit_sense      = (addr == EPI_OFS_SENSE);
   assign hit_pc_mask0   = (addr == EPI_OFS_PC_MASK0);
   assign hit_pc_mask1   = (addr == EPI_OFS_PC_MASK1);
   assign hit_pc_mask2   = (addr == EPI_OFS_PC_MASK2);

   // flag clears: routine entry or a one written to the flag bit
   for (c = 0; c < 2; c++) begin : g_ext_clr
      assign ext_clr[c] = irq_ack[c] | (reg_wr & hit_ext_flags & reg_wdata[c]);
   end

   for (c = 0; c < 3; c++) begin : g_grp_clr
      assign grp_clr[c] = irq_ack[2 + c] | (reg_wr & hit_pc_flags & reg_wdata[c]);
   end

   always_comb begin
      next_st = st;
      // hardware sets, acknowledge and write-one clear; set wins
      for (int k = 0; k < 2; k++) begin
         if (ext_clr[k]) begin
            next_st.ext_irq_flags[k] = 1'b0;
         end
         if (trig[k] && !level_mode[k]) begin
            next_st.ext_irq_flags[k] = 1'b1;
         end
         if (level_mode[k]) begin
            next_st.ext_irq_flags[k] = 1'b0;
         end
      end
      for (int g = 0; g < 3; g++) begin
         if (grp_clr[g]) begin
            next_st.pin_change_flags[g] = 1'b0;
         end
         if (grp_change[g]) begin
            next_st.pin_change_flags[g] = 1'b1;
         end
      end
      // control registers keep only their defined bits
      if (reg_wr && hit_ext_enable) begin
         next_st.ext_irq_enable_mask = {6'h0, reg_wdata[1:0]};
      end
      if (reg_wr && hit_sense) begin
         next_st.ext_irq_sense_control = {4'h0, reg_wdata[3:0]};
      end
      if (reg_wr && hit_pc_control) begin
         next_st.pin_change_group_control = {5'h0, reg_wdata[2:0]};
      end
      if (reg_wr && hit_pc_mask0) begin
         next_st.pin_change_mask_group0 = reg_wdata;
      end
      if (reg_wr && hit_pc_mask1) begin
         next_st.pin_change_mask_group1 = {1'b0, reg_wdata[6:0]};
      end
      if (reg_wr && hit_pc_mask2) begin
         next_st.pin_change_mask_group2 = reg_wdata;
      end
      if (reg_rd) begin
         case (addr)
            EPI_OFS_EXT_FLAGS:  next_st.rdata = st.ext_irq_flags;
            EPI_OFS_EXT_ENABLE: next_st.rdata = st.ext_irq_enable_mask;
            EPI_OFS_PC_FLAGS:   next_st.rdata = st.pin_change_flags;
            EPI_OFS_PC_CONTROL: next_st.rdata = st.pin_change_group_control;
            EPI_OFS_SENSE:      next_st.rdata = st.ext_irq_sense_control;
            EPI_OFS_PC_MASK0:   next_st.rdata = st.pin_change_mask_group0;
            EPI_OFS_PC_MASK1:   next_st.rdata = st.pin_change_mask_group1;
            EPI_OFS_PC_MASK2:   next_st.rdata = st.pin_change_mask_group2;
            default:            next_st.rdata = EPI_REG_RESET;
         endcase
      end
      // requests gated by global flag and enables
      for (int k = 0; k < 2; k++) begin
         next_st.req[k] = core_status_word_i & st.ext_irq_enable_mask[k]
                        & ded_src[k];
      end
      for (int g = 0; g < 3; g++) begin
         next_st.req[2 + g] = core_status_word_i & st.pin_change_group_control[g]
                            & st.pin_change_flags[g];
      end
      next_st.wake = low_wake | (|grp_wake) | (|next_st.req);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st.ext_irq_flags            <= EPI_REG_RESET;
         st.ext_irq_enable_mask      <= EPI_REG_RESET;
         st.ext_irq_sense_control    <= EPI_REG_RESET;
         st.pin_change_flags         <= EPI_REG_RESET;
         st.pin_change_group_control <= EPI_REG_RESET;
         st.pin_change_mask_group0   <= EPI_REG_RESET;
         st.pin_change_mask_group1   <= EPI_REG_RESET;
         st.pin_change_mask_group2   <= EPI_REG_RESET;
         st.rdata                    <= EPI_REG_RESET;
         st.req                      <= 5'h00;
         st.wake                     <= 1'b0;
      end else begin
         st.ext_irq_flags            <= next_st.ext_irq_flags;
         st.ext_irq_enable_mask      <= next_st.ext_irq_enable_mask;
         st.ext_irq_sense_control    <= next_st.ext_irq_sense_control;
         st.pin_change_flags         <= next_st.pin_change_flags;
         st.pin_change_group_control <= next_st.pin_change_group_control;
         st.pin_change_mask_group0   <= next_st.pin_change_mask_group0;
         st.pin_change_mask_group1   <= next_st.pin_change_mask_group1;
         st.pin_change_mask_group2   <= next_st.pin_change_mask_group2;
         st.rdata                    <= next_st.rdata;
         st.req                      <= next_st.req;
         st.wake                     <= next_st.wake;
      end
   end

   assign reg_rdata = st.rdata;
   assign irq_req   = st.req;
   assign wake_req  = st.wake;
endmodule : epi_unit
`default_nettype wire

// >>> tb/epi_core_model.sv
// core-side partner: routine-entry acknowledge per raised request
`timescale 1ns/1ps
`default_nettype none
module epi_core_model (
   // clock
   input  wire logic       sys_clk,
   // control and requests
   input  wire logic       ack_en,
   input  wire logic [4:0] irq_req,
   // routine entry pulses
   output var  logic [4:0] irq_ack
);
   logic [4:0] ack_prev = 5'h00;
   initial irq_ack = 5'h00;
   // one-cycle entry pulse per raised vector; the request lingers one cycle
   // after the clear, so a second entry is held off for that cycle
   always @(posedge sys_clk) begin
      ack_prev <= irq_ack;
      irq_ack  <= #1 irq_req & ~irq_ack & ~ack_prev & {5{ack_en}};
   end
endmodule : epi_core_model
`default_nettype wire

// >>> tb/epi_unit_asserts.sv
// assertion checker for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module epi_unit_asserts (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       arst_n,
   // observed ports
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       core_status_word_i,
   input wire logic [4:0] irq_ack,
   input wire logic [4:0] irq_req,
   input wire logic       wake_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_gie_off; !core_status_word_i [*3]; endsequence
   sequence s_grp_ack; irq_ack[2] && irq_req[2]; endsequence
   property p_gie_gate; s_gie_off |-> irq_req == 5'h00; endproperty
   property p_pin0_cause;
      $rose(irq_req[0]) |-> core_status_word_i || $past(core_status_word_i);
   endproperty
   property p_pin1_cause;
      $rose(irq_req[1]) |-> core_status_word_i || $past(core_status_word_i);
   endproperty
   property p_grp_cause;
      $rose(|irq_req[4:2]) |-> core_status_word_i || $past(core_status_word_i);
   endproperty
   property p_wake; |irq_req |-> wake_req; endproperty
   property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   property p_reset_quiet; $rose(arst_n) |-> irq_req == 5'h00 ##1 irq_req == 5'h00; endproperty
   property p_grp_ack; s_grp_ack |-> ##[1:2] !irq_req[2]; endproperty
   a_gie_gate: assert property (p_gie_gate) else $error("request with flag low");
   a_pin0_cause: assert property (p_pin0_cause) else $error("pin zero ungated");
   a_pin1_cause: assert property (p_pin1_cause) else $error("pin one ungated");
   a_grp_cause: assert property (p_grp_cause) else $error("group ungated");
   a_wake: assert property (p_wake) else $error("wake missing");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   a_reset_quiet: assert property (p_reset_quiet) else $error("request after reset");
   a_grp_ack: assert property (p_grp_ack) else $error("group ack ignored");
endmodule : epi_unit_asserts
bind epi_unit epi_unit_asserts epi_unit_asserts_i (.sys_clk(sys_clk), .arst_n(arst_n),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_status_word_i(core_status_word_i),
   .irq_ack(irq_ack), .irq_req(irq_req), .wake_req(wake_req));
`default_nettype wire

// >>> tb/external_pin_interrupt_unit_bench.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupt_unit_bench;
   logic        sys_clk, arst_n, reg_io_space, reg_wr, reg_rd, gie, ack_en, p0, p1, wake_req;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [4:0]  irq_ack, irq_req;
   logic [23:0] pc;
   logic [31:0] lfsr = 32'h0000_cf83;
   int          fails = 0, compares = 0, cycles = 0;
   logic [7:0]  ofs [8] = '{8'h3b, 8'h3c, 8'h3d, 8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6d};
   logic [7:0]  msk [8] = '{8'h07, 8'h03, 8'h03, 8'h07, 8'h0f, 8'hff, 8'h7f, 8'hff};
   epi_unit epi_unit_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_io_space(reg_io_space), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .core_status_word_i(gie), .irq_ack(irq_ack), .irq_req(irq_req),
      .wake_req(wake_req), .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1), .pin_change_input(pc));
   epi_core_model epi_core_model_i (.sys_clk(sys_clk), .ack_en(ack_en), .irq_req(irq_req),
      .irq_ack(irq_ack));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic wrap_up;
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         wrap_up();
      end
   end
   function automatic logic [31:0] nxt(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   // model: change always, falling on low, rising on high
   function automatic int trig(int m, int v);
      return int'(m == 1 || m == 2 + v);
   endfunction : trig
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic io, logic [7:0] d);
      reg_addr = a;
      reg_io_space = io;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask : wr
   task automatic rc(string n, logic [7:0] a, logic io, logic [7:0] e);
      reg_addr = a;
      reg_io_space = io;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
      chk(n, e, reg_rdata);
   endtask : rc
   task automatic edge_step(int p, int m, int v);
      int e;
      e = trig(m, v);
      if (p == 0) p0 = v[0];
      else p1 = v[0];
      tick(6);
      wr(8'h3c, 1'b0, 8'(2 >> p));
      rc("ext flag", 8'h3c, 1'b0, 8'(e << p));
      chk("ext req", 8'(e << p), {3'h0, irq_req});
      wr(8'h3c, 1'b0, 8'(1 << p));
      rc("ext clear", 8'h3c, 1'b0, 8'h00);
   endtask : edge_step
   initial begin
      {arst_n, reg_io_space, reg_wr, reg_rd, gie, ack_en} = 6'h00;
      {reg_addr, reg_wdata, pc, p0, p1} = 42'h003_0000_0003;
      tick(2);
      arst_n = 1'b1;
      tick(3);
      foreach (ofs[i]) rc("reset", ofs[i], 1'b0, 8'h00);
      for (int i = 2; i < 8; i++) begin
         lfsr = nxt(lfsr);
         wr(ofs[i], 1'b0, lfsr[7:0]);
         rc("rw", ofs[i], 1'b0, lfsr[7:0] & msk[i]);
         wr(ofs[i], 1'b0, 8'h00);
      end
      wr(8'h1d, 1'b1, 8'h03);
      rc("io", 8'h3d, 1'b0, 8'h03);
      wr(8'h68, 1'b0, 8'h07);
      rc("io high", 8'h48, 1'b1, 8'h00);
      wr(8'h50, 1'b0, 8'hff);
      rc("unmapped", 8'h50, 1'b0, 8'h00);
      wr(8'h68, 1'b0, 8'h00);
      gie = 1'b1;
      for (int p = 0; p < 2; p++) begin
         for (int m = 1; m < 4; m++) begin
            wr(8'h69, 1'b0, 8'(m << (2 * p)));
            wr(8'h3d, 1'b0, 8'(1 << p));
            edge_step(p, m, 0);
            edge_step(p, m, 1);
         end
      end
      wr(8'h69, 1'b0, 8'h02);
      wr(8'h3d, 1'b0, 8'h01);
      p0 = 1'b0;
      tick(2);
      p0 = 1'b1;
      tick(6);
      rc("short pulse", 8'h3c, 1'b0, 8'h01);
      wr(8'h3c, 1'b0, 8'h01);
      wr(8'h69, 1'b0, 8'h00);
      wr(8'h3d, 1'b0, 8'h03);
      p0 = 1'b0;
      tick(6);
      rc("level flag", 8'h3c, 1'b0, 8'h00);
      chk("level req", 8'h01, {3'h0, irq_req});
      chk("wake", 8'h01, {7'h0, wake_req});
      gie = 1'b0;
      tick(4);
      chk("gated", 8'h00, {3'h0, irq_req});
      gie = 1'b1;
      p0 = 1'b1;
      tick(6);
      chk("level end", 8'h00, {3'h0, irq_req});
      wr(8'h3d, 1'b0, 8'h00);
      ack_en = 1'b1;
      for (int g = 0; g < 3; g++) begin
         lfsr = nxt(lfsr);
         gie = 1'b0;
         wr(8'h6b + 8'(g), 1'b0, (lfsr[7:0] | 8'h01) & 8'hfd);
         wr(8'h68, 1'b0, 8'h00);
         pc[8*g] = ~pc[8*g];
         tick(6);
         rc("group off", 8'h3b, 1'b0, 8'h00);
         wr(8'h68, 1'b0, 8'(1 << g));
         pc[8*g+1] = ~pc[8*g+1];
         tick(6);
         rc("masked pin", 8'h3b, 1'b0, 8'h00);
         pc[8*g] = ~pc[8*g];
         tick(6);
         rc("group flag", 8'h3b, 1'b0, 8'(1 << g));
         chk("group gated", 8'h00, {3'h0, irq_req});
         gie = 1'b1;
         tick(1);
         chk("group req on", 8'(4 << g), {3'h0, irq_req});
         chk("group wake", 8'h01, {7'h0, wake_req});
         tick(5);
         rc("group entry", 8'h3b, 1'b0, 8'h00);
         chk("group req", 8'h00, {3'h0, irq_req});
      end
      tick(2);
      wrap_up();
   end
endmodule : external_pin_interrupt_unit_bench
`default_nettype wire
